/* File: common/lkd_pkg.sv */
// shared constants, types and helpers of the lcd key driver reset block
package lkd_pkg;
    // ****************************************
    // serial frame layout
    // ****************************************
    localparam int KIND_W = 8;
    localparam int PAYLOAD_W = 60;
    localparam int FRAME_W = KIND_W + PAYLOAD_W;
    localparam logic [3:0] KIND_DISP_HI = 4'h1;
    localparam logic [7:0] KIND_CTRL = 8'h20;
    localparam logic [7:0] KIND_KEY_READ = 8'h30;
    // ****************************************
    // display and key geometry
    // ****************************************
    localparam int SEG_W = 60;
    localparam int N_COM_MAX = 10;
    localparam int N_SCAN = 6;
    localparam int N_KEY_IN = 5;
    localparam int SLOT_OSC = 64;
    localparam int KEY_SCAN_OSC = 384;
    localparam int KEY_LINE_OSC = KEY_SCAN_OSC / N_SCAN;
    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_KEY = 8'h08;
    localparam logic [7:0] REG_SWRST = 8'h0C;
    localparam logic [1:0] DUTY_8 = 2'h0;
    localparam logic [1:0] DUTY_9 = 2'h1;
    localparam logic [1:0] DUTY_10 = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef struct packed {
        logic [1:0] duty;
        logic sleep_select_bit;
        logic contrast_enable_bit;
        logic [3:0] contrast_level_field;
        logic [3:0] general_outputs;
        logic [5:0] scan_line_level_bits;
    } lkd_ctrl_type;
    localparam int CTRL_W = $bits(lkd_ctrl_type);
    localparam lkd_ctrl_type CTRL_RESET = '{duty: DUTY_9, default: '0};
    typedef struct packed {
        logic [KIND_W-1:0] kind;
        logic [PAYLOAD_W-1:0] payload;
    } lkd_frame_type;
    function automatic logic [15:0] lkd_onehot(input logic [3:0] idx);
        lkd_onehot = 16'h0001 << idx;
    endfunction
endpackage

/* File: rtl/lkd_key_scan.sv */
// key scanner with double-scan agreement and read request
`timescale 1ns/100ps
module lkd_key_scan #(
    parameter int LINE_OSC = lkd_pkg::KEY_LINE_OSC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_tick,
    input wire logic clear,
    input wire logic [lkd_pkg::N_SCAN-1:0] line_levels,
    input wire logic [lkd_pkg::N_KEY_IN-1:0] key_in,
    input wire logic read_ack,
    output logic [lkd_pkg::N_SCAN-1:0] scan_drive,
    output logic [lkd_pkg::N_SCAN*lkd_pkg::N_KEY_IN-1:0] key_data,
    output logic key_req,
    output logic busy
);
    import lkd_pkg::*;
    localparam int KW = N_SCAN * N_KEY_IN;
    logic [N_KEY_IN-1:0] k_m_q;
    logic [N_KEY_IN-1:0] k_s_q;
    logic [7:0] step_q;
    logic [2:0] line_q;
    logic pass_q;
    logic [KW-1:0] snap_q;
    logic [KW-1:0] first_q;
    logic [KW-1:0] snap_d;
    logic [15:0] line_oh;
    assign line_oh = lkd_onehot({1'b0, line_q});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k_m_q <= '0;
            k_s_q <= '0;
        end else begin
            k_m_q <= key_in;
            k_s_q <= k_m_q;
        end
    end
    always_comb begin
        snap_d = snap_q;
        snap_d[line_q*N_KEY_IN +: N_KEY_IN] = k_s_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy, pass_q, key_req} <= 3'h0;
            step_q <= 8'h00;
            line_q <= 3'h0;
            {snap_q, first_q, key_data} <= '0;
            scan_drive <= '0;
        end else if (clear) begin
            {busy, pass_q, key_req} <= 3'h0;
            step_q <= 8'h00;
            line_q <= 3'h0;
            {snap_q, first_q, key_data} <= '0;
            scan_drive <= '0;
        end else begin
            if (read_ack) begin
                key_req <= 1'b0;
            end
            if (!busy) begin
                scan_drive <= line_levels;
                if (osc_tick && (|k_s_q) && !key_req) begin
                    busy <= 1'b1;
                    pass_q <= 1'b0;
                    line_q <= 3'h0;
                    step_q <= 8'h00;
                end
            end else begin
                scan_drive <= line_levels & line_oh[N_SCAN-1:0];
                if (osc_tick) begin
                    step_q <= step_q + 8'h01;
                    if (step_q == 8'(LINE_OSC - 1)) begin
                        step_q <= 8'h00;
                        snap_q <= snap_d;
                        line_q <= line_q + 3'h1;
                        if (line_q == 3'(N_SCAN - 1)) begin
                            line_q <= 3'h0;
                            pass_q <= ~pass_q;
                            first_q <= snap_d;
                            // a mismatch simply runs two more passes
                            if (pass_q && snap_d == first_q) begin
                                busy <= 1'b0;
                                key_data <= snap_d;
                                key_req <= |snap_d;
                            end
                        end
                    end
                end
            end
        end
    end
endmodule

/* File: rtl/lkd_ser_rx.sv */
// serial frame receiver, kept alive through system reset
`timescale 1ns/100ps
module lkd_ser_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ser_clk,
    input wire logic ser_ce,
    input wire logic ser_din,
    output lkd_pkg::lkd_frame_type frame,
    output logic frame_valid,
    output logic ce_active
);
    import lkd_pkg::*;
    logic [2:0] m_q;
    logic [2:0] s_q;
    logic clk_prev_q;
    logic [FRAME_W-1:0] shift_q;
    logic [7:0] count_q;
    // only presetn clears these, so frames pass during system reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_q <= 3'h0;
            s_q <= 3'h0;
            clk_prev_q <= 1'b0;
        end else begin
            m_q <= {ser_clk, ser_ce, ser_din};
            s_q <= m_q;
            clk_prev_q <= s_q[2];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= '0;
            count_q <= 8'h00;
            frame_valid <= 1'b0;
            ce_active <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            ce_active <= s_q[1];
            if (s_q[1] && s_q[2] && !clk_prev_q) begin
                shift_q <= {shift_q[FRAME_W-2:0], s_q[0]};
                count_q <= (count_q == 8'hFF) ? count_q : count_q + 8'h01;
            end else if (!s_q[1] && ce_active) begin
                // short or long frames are dropped whole
                frame_valid <= (count_q == 8'(FRAME_W));
                count_q <= 8'h00;
            end
        end
    end
    assign frame = lkd_frame_type'(shift_q);
endmodule

/* File: rtl/lkd_sys_reset.sv */
// system reset sequencer of the lcd key driver, with apb status and display scan
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// What this block does
// - reset blanks display, stops keys, lowers ports
// - display on after display and control data
// - control data enables key scan, releases keys
// - control data frees ports, sets their levels
// - clock generator held; sleep set by control
// - display data latched even while blanked
// - contrast disabled until control data arrives
// - key logic initialised, key data zeroed
// - serial receiver and control register unreset
// - reset at power-up and supply drop
// - outputs lowest level, key request released
// - key request stays released before control
module lkd_sys_reset #(
    parameter int SLOT_TICKS = lkd_pkg::SLOT_OSC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_drop_detector,
    input wire logic oscillator_pin,
    input wire logic ser_clk,
    input wire logic ser_ce,
    input wire logic ser_din,
    input wire logic [lkd_pkg::N_KEY_IN-1:0] key_inputs,
    output logic key_req_out,
    output logic key_req_oe,
    output logic [lkd_pkg::SEG_W-1:0] segment_outputs,
    output logic [lkd_pkg::N_COM_MAX-1:0] common_outputs,
    output logic [lkd_pkg::N_SCAN-1:0] scan_drive_outputs,
    output logic [3:0] general_outputs,
    output logic [3:0] contrast_level,
    output logic contrast_on,
    output logic base_clk_run,
    output logic sleep_mode,
    output logic display_on
);
    import lkd_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic det_m_q;
    logic det_s_q;
    logic osc_m_q;
    logic osc_s_q;
    logic osc_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_m_q <= 1'b0;
            det_s_q <= 1'b0;
        end else begin
            det_m_q <= supply_drop_detector;
            det_s_q <= det_m_q;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_m_q <= 1'b0;
            osc_s_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_m_q <= oscillator_pin;
            osc_s_q <= osc_m_q;
            osc_prev_q <= osc_s_q;
        end
    end

    // ****************************************
    // system reset sources
    // ****************************************
    logic por_q;
    logic swrst_q;
    logic sys_rst;
    // por_q gives one reset cycle after logic power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_q <= 1'b1;
        end else begin
            por_q <= 1'b0;
        end
    end
    assign sys_rst = por_q | det_s_q | swrst_q;

    // ****************************************
    // serial receiver
    // ****************************************
    lkd_frame_type frame;
    logic frame_valid;
    logic ce_active;
    logic ctrl_frame;
    logic disp_frame;
    logic key_read;
    logic [3:0] disp_idx;
    lkd_ser_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .ser_clk(ser_clk),
        .ser_ce(ser_ce),
        .ser_din(ser_din),
        .frame(frame),
        .frame_valid(frame_valid),
        .ce_active(ce_active)
    );
    assign disp_idx = frame.kind[3:0];
    assign disp_frame = frame_valid && frame.kind[7:4] == KIND_DISP_HI && disp_idx < 4'(N_COM_MAX);
    assign ctrl_frame = frame_valid && frame.kind == KIND_CTRL;
    assign key_read = frame_valid && frame.kind == KIND_KEY_READ;

    // ****************************************
    // control register, never cleared by system reset
    // ****************************************
    lkd_ctrl_type ctrl_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_frame) begin
            ctrl_q <= lkd_ctrl_type'(frame.payload[CTRL_W-1:0]);
        end
    end

    // ****************************************
    // display latch
    // ****************************************
    logic [SEG_W-1:0] disp_mem [N_COM_MAX];
    // written regardless of the blanking flag
    always_ff @(posedge pclk) begin
        if (disp_frame) begin
            disp_mem[disp_idx] <= frame.payload[SEG_W-1:0];
        end
    end

    // ****************************************
    // release flags, one per reset state
    // ****************************************
    logic blank_q;
    logic key_hold_q;
    logic port_hold_q;
    logic clk_hold_q;
    logic contrast_hold_q;
    logic ctrl_got_q;
    logic [N_COM_MAX-1:0] disp_seen_q;
    logic [N_COM_MAX-1:0] disp_need;
    logic [3:0] n_com;
    logic [15:0] need_oh;
    logic [15:0] idx_oh;
    assign idx_oh = lkd_onehot(disp_idx);
    always_comb begin
        case (ctrl_q.duty)
            DUTY_8: n_com = 4'h8;
            DUTY_10: n_com = 4'hA;
            default: n_com = 4'h9;
        endcase
        need_oh = lkd_onehot(n_com);
        disp_need = need_oh[N_COM_MAX-1:0] - 10'h001;
        if (n_com == 4'(N_COM_MAX)) begin
            disp_need = '1;
        end
    end
    // sys_rst has priority, so a release frame during reset is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_seen_q <= '0;
            ctrl_got_q <= 1'b0;
        end else if (sys_rst) begin
            disp_seen_q <= '0;
            ctrl_got_q <= 1'b0;
        end else begin
            if (disp_frame) begin
                disp_seen_q <= disp_seen_q | idx_oh[N_COM_MAX-1:0];
            end
            if (ctrl_frame) begin
                ctrl_got_q <= 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_q <= 1'b1;
        end else if (sys_rst) begin
            blank_q <= 1'b1;
        end else if (ctrl_got_q && (disp_seen_q & disp_need) == disp_need) begin
            blank_q <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {key_hold_q, port_hold_q, clk_hold_q, contrast_hold_q} <= 4'hF;
        end else if (sys_rst) begin
            {key_hold_q, port_hold_q, clk_hold_q, contrast_hold_q} <= 4'hF;
        end else if (ctrl_frame) begin
            key_hold_q <= 1'b0;
            port_hold_q <= 1'b0;
            clk_hold_q <= 1'b0;
            contrast_hold_q <= 1'b0;
        end
    end

    // ****************************************
    // oscillator timebase
    // ****************************************
    logic osc_tick;
    logic key_busy;
    // in sleep ticks pass only while a key scan is already busy; a new key press cannot start one
    assign osc_tick = osc_s_q && !osc_prev_q && !clk_hold_q && (!ctrl_q.sleep_select_bit || key_busy);

    // ****************************************
    // key scanning
    // ****************************************
    logic [N_SCAN-1:0] scan_drive;
    logic [N_SCAN*N_KEY_IN-1:0] key_data;
    logic key_pending;
    lkd_key_scan u_keys (
        .pclk(pclk),
        .presetn(presetn),
        .osc_tick(osc_tick),
        .clear(key_hold_q),
        .line_levels(ctrl_q.scan_line_level_bits),
        .key_in(key_inputs),
        .read_ack(key_read),
        .scan_drive(scan_drive),
        .key_data(key_data),
        .key_req(key_pending),
        .busy(key_busy)
    );
    // request pin pulled low only once scanning is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_req_oe <= 1'b0;
            key_req_out <= 1'b0;
            scan_drive_outputs <= '0;
        end else begin
            key_req_oe <= key_pending && !key_hold_q && !ce_active;
            key_req_out <= 1'b0;
            scan_drive_outputs <= key_hold_q ? '0 : scan_drive;
        end
    end

    // ****************************************
    // common sequencer and drivers
    // ****************************************
    logic [7:0] slot_cnt_q;
    logic [3:0] slot_q;
    logic [15:0] slot_oh;
    assign slot_oh = lkd_onehot(slot_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_q <= 8'h00;
            slot_q <= 4'h0;
        end else if (clk_hold_q) begin
            slot_cnt_q <= 8'h00;
            slot_q <= 4'h0;
        end else if (osc_tick) begin
            slot_cnt_q <= slot_cnt_q + 8'h01;
            if (slot_cnt_q == 8'(SLOT_TICKS - 1)) begin
                slot_cnt_q <= 8'h00;
                slot_q <= (slot_q >= n_com - 4'h1) ? 4'h0 : slot_q + 4'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            segment_outputs <= '0;
            common_outputs <= '0;
            display_on <= 1'b0;
        end else begin
            display_on <= !blank_q;
            if (blank_q) begin
                segment_outputs <= '0;
                common_outputs <= '0;
            end else begin
                segment_outputs <= disp_mem[slot_q];
                common_outputs <= slot_oh[N_COM_MAX-1:0];
            end
        end
    end

    // ****************************************
    // ports, contrast and clock status
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_outputs <= 4'h0;
            contrast_level <= 4'h0;
            contrast_on <= 1'b0;
            base_clk_run <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            general_outputs <= port_hold_q ? 4'h0 : ctrl_q.general_outputs;
            contrast_on <= !contrast_hold_q && ctrl_q.contrast_enable_bit;
            contrast_level <= contrast_hold_q ? 4'h0 : ctrl_q.contrast_level_field;
            base_clk_run <= !clk_hold_q && !ctrl_q.sleep_select_bit;
            sleep_mode <= !clk_hold_q && ctrl_q.sleep_select_bit;
        end
    end

    // ****************************************
    // apb slave, one wait state per access
    // ****************************************
    logic access;
    logic [31:0] rd_word;
    logic rd_err;
    assign access = psel && penable && !pready;
    always_comb begin
        rd_err = 1'b0;
        case (paddr)
            REG_STATUS: rd_word = {14'h0000, disp_seen_q, 1'b0, key_pending, sys_rst, contrast_hold_q,
                                   clk_hold_q, port_hold_q, key_hold_q, blank_q};
            REG_CTRL: rd_word = 32'(ctrl_q);
            REG_KEY: rd_word = 32'(key_data);
            REG_SWRST: rd_word = {31'h0000_0000, swrst_q};
            default: begin
                rd_word = RESET_WORD;
                rd_err = 1'b1;
            end
        endcase
    end
    // software reset holds the system reset until written back to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrst_q <= 1'b0;
        end else if (access && pwrite && paddr == REG_SWRST) begin
            swrst_q <= pwdata[0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RESET_WORD;
        end else begin
            pready <= access;
            pslverr <= access && (pwrite ? (paddr != REG_SWRST) : rd_err);
            if (access && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end
endmodule

/* File: tb/lkd_ser_host.sv */
// system controller model driving the serial link
`timescale 1ns/100ps
module lkd_ser_host (
    input wire logic pclk,
    output logic ser_clk,
    output logic ser_ce,
    output logic ser_din
);
    import lkd_pkg::*;
    // ****************************************
    // frame sender
    // ****************************************
    initial begin
        ser_clk = 1'b0;
        ser_ce = 1'b0;
        ser_din = 1'b1;
    end
    // clock stands still between frames, 80 ns bit period
    task automatic send(input lkd_frame_type f, input int nbits);
        @(posedge pclk);
        ser_ce <= 1'b1;
        for (int i = 0; i < nbits; i++) begin
            ser_din <= f[FRAME_W-1-i];
            repeat (4) @(posedge pclk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ser_clk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        ser_ce <= 1'b0;
        ser_din <= ~ser_din;
    endtask
endmodule

/* File: tb/lkd_sys_reset_asserts.sv */
// concurrent checks on the ports of the system reset sequencer
`timescale 1ns/100ps
module lkd_sys_reset_asserts #(
    parameter int SLOT_TICKS = lkd_pkg::SLOT_OSC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supply_drop_detector,
    input wire logic ser_ce,
    input wire logic key_req_out,
    input wire logic key_req_oe,
    input wire logic [lkd_pkg::SEG_W-1:0] segment_outputs,
    input wire logic [lkd_pkg::N_COM_MAX-1:0] common_outputs,
    input wire logic [lkd_pkg::N_SCAN-1:0] scan_drive_outputs,
    input wire logic [3:0] general_outputs,
    input wire logic contrast_on,
    input wire logic base_clk_run,
    input wire logic sleep_mode,
    input wire logic display_on
);
    import lkd_pkg::*;
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // detector level must survive the two sync flops
    sequence s_drop;
        $rose(supply_drop_detector) ##1 supply_drop_detector;
    endsequence
    a_apb_wait: assert property (s_access |-> !pready ##1 pready)
        else $error("apb wait state wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_blank_dark: assert property (!display_on [*2] |-> segment_outputs == '0 && common_outputs == '0)
        else $error("panel driven while blanked");
    a_drop_quiet: assert property (s_drop |-> ##[1:6] (general_outputs == '0 && !display_on && !contrast_on
        && !base_clk_run && scan_drive_outputs == '0)) else $error("supply drop left outputs active");
    a_clk_excl: assert property (!(base_clk_run && sleep_mode))
        else $error("run and sleep together");
    a_pin_data: assert property (key_req_out == 1'b0)
        else $error("key request data not low");
    a_ce_release: assert property (ser_ce [*5] |-> !key_req_oe)
        else $error("key request pulled during transfer");
    a_com_onehot: assert property ($onehot0(common_outputs))
        else $error("more than one common active");
    a_com_step: assert property ($changed(common_outputs) && $past(common_outputs) != '0 && common_outputs != '0
        |-> common_outputs == 10'h001 || common_outputs == $past(common_outputs) << 1) else $error("common order");
endmodule
bind lkd_sys_reset lkd_sys_reset_asserts #(.SLOT_TICKS(SLOT_TICKS)) i_chk (.*);

/* File: tb/tb_lkd_sys_reset.sv */
// self-checking testbench of the lcd key driver system reset sequencer
`timescale 1ns/100ps
module tb_lkd_sys_reset;
    import lkd_pkg::*;
    localparam int SLOT = 4;
    logic pclk, presetn, psel, penable, pwrite, supply_drop_detector, oscillator_pin, press;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, key_req_out, key_req_oe, contrast_on, base_clk_run, sleep_mode, display_on;
    logic [N_KEY_IN-1:0] key_inputs;
    logic [SEG_W-1:0] segment_outputs;
    logic [N_COM_MAX-1:0] common_outputs;
    logic [N_SCAN-1:0] scan_drive_outputs;
    logic [3:0] general_outputs, contrast_level;
    wire ser_clk, ser_ce, ser_din;
    int miscompares, num_checks;
    lkd_ctrl_type c;
    lkd_sys_reset #(.SLOT_TICKS(SLOT)) i_dut (.*);
    lkd_ser_host i_host (.*);
    // ****************************************
    // stimulus and helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // oscillator of two clocks keeps slot and scan counts short; key sits on line 1, return 2
    always @(posedge pclk) begin
        oscillator_pin <= ~oscillator_pin;
        key_inputs <= (press && scan_drive_outputs[1]) ? 5'h04 : 5'h00;
    end
    function automatic logic [59:0] row(input int k);
        return {15{4'(k + 1)}};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [32:0] x);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & {1'b1, m}, x);
    endtask
    task automatic tx(input logic [7:0] k, input logic [59:0] p, input int nb);
        i_host.send({k, p}, nb);
        repeat (12) @(negedge pclk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [32:0] r;
        repeat (5) @(negedge pclk);
        chk({display_on, general_outputs, contrast_on, contrast_level, base_clk_run, sleep_mode, key_req_oe}, 0);
        chk(scan_drive_outputs, 0);
        rd(REG_STATUS, 32'h1F, 33'h1F);
        rd(REG_KEY, '1, 0);
        rd(REG_CTRL, '1, 33'(CTRL_RESET));
        rd(8'h10, '1, 33'h1_0000_0000);
        apb(1'b1, REG_STATUS, 32'h1, r);
        chk(r[32], 1'b1);
    endtask
    task automatic t_rows();
        for (int n = 0; n < 9; n++) tx({KIND_DISP_HI, 4'(n)}, row(n), 68);
        chk(display_on, 1'b0);
        rd(REG_STATUS, 32'h3FF01, 33'h1FF01);
    endtask
    task automatic t_ctrl();
        tx(KIND_CTRL, 60'(c), 68);
        chk({general_outputs, contrast_on, contrast_level}, {4'hA, 1'b1, 4'h5});
        chk({base_clk_run, sleep_mode, display_on}, 3'b101);
        rd(REG_STATUS, 32'h1F, 0);
        rd(REG_CTRL, '1, 33'(c));
    endtask
    task automatic t_scan();
        int n;
        n = 0;
        while (common_outputs === 10'h001 && n++ < 400) @(negedge pclk);
        while (common_outputs !== 10'h001 && n++ < 400) @(negedge pclk);
        repeat (SLOT) @(negedge pclk);
        for (int k = 0; k < 10; k++) begin
            chk(common_outputs, 10'h001 << (k % 9));
            chk(segment_outputs, row(k % 9));
            repeat (SLOT * 2) @(negedge pclk);
        end
    endtask
    task automatic t_key();
        int n;
        n = 0;
        @(posedge pclk);
        press <= 1'b1;
        while (key_req_oe !== 1'b1 && n++ < 8000) @(negedge pclk);
        chk(key_req_oe, 1'b1);
        rd(REG_KEY, '1, 33'h80);
        press <= 1'b0;
        tx(KIND_KEY_READ, 0, 68);
        chk(key_req_oe, 1'b0);
    endtask
    task automatic t_drop();
        logic [32:0] r;
        @(posedge pclk);
        supply_drop_detector <= 1'b1;
        repeat (8) @(negedge pclk);
        chk({display_on, general_outputs, contrast_on, base_clk_run, scan_drive_outputs}, 0);
        rd(REG_KEY, '1, 0);
        c.general_outputs = 4'h5;
        tx(KIND_CTRL, 60'(c), 68);
        chk(general_outputs, 4'h0);
        rd(REG_CTRL, '1, 33'(c));
        @(posedge pclk);
        supply_drop_detector <= 1'b0;
        tx(KIND_CTRL, 60'(c), 67);
        chk(general_outputs, 4'h0);
        tx(KIND_CTRL, 60'(c), 68);
        chk({general_outputs, display_on}, {4'h5, 1'b0});
        apb(1'b1, REG_SWRST, 32'h1, r);
        rd(REG_STATUS, 32'h20, 33'h20);
        apb(1'b1, REG_SWRST, 32'h0, r);
        chk({r[32], general_outputs}, 0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, supply_drop_detector, oscillator_pin, press} = '0;
        {paddr, pwdata, key_inputs} = '0;
        miscompares = 0;
        num_checks = 0;
        c = '{DUTY_9, 1'b0, 1'b1, 4'h5, 4'hA, 6'h3F};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rows();
        t_ctrl();
        t_scan();
        t_key();
        t_drop();
        print_verdict();
    end
    // whole run stays well under this span
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule
